// ---- cdir_pkg.sv ----
// Package of constants and types for the carrier diagnostic register block.
package cdir_pkg;

  // ==========================================================================
  // Register offsets inside the 4 KB short I/O block
  // ==========================================================================
  localparam logic [11:0] OFS_LAMP_CONTROL = 12'h400;
  localparam logic [11:0] OFS_LIVE_STATUS = 12'h402;
  localparam logic [11:0] OFS_EDGE_POLARITY = 12'h404;
  localparam logic [11:0] OFS_IRQ_ENABLE_MASK = 12'h406;
  localparam logic [11:0] OFS_PENDING_CLEAR = 12'h408;
  localparam logic [11:0] OFS_PENDING_LATCHES = 12'h40A;
  localparam logic [11:0] OFS_IRQ_VECTOR = 12'h40C;
  localparam logic [3:0] DIAG_PAGE = 4'h4;
  localparam logic [11:0] OFS_ID_BASE = 12'h480;
  localparam logic [11:0] OFS_ID_SIG_CHAR0 = 12'h481;
  localparam logic [11:0] OFS_ID_SIG_CHAR1 = 12'h483;
  localparam logic [11:0] OFS_ID_SIG_CHAR2 = 12'h485;
  localparam logic [11:0] OFS_ID_SIG_CHAR3 = 12'h487;
  localparam logic [11:0] OFS_ID_MAKER_CODE = 12'h489;
  localparam logic [11:0] OFS_ID_MODEL_CODE = 12'h48B;
  localparam logic [11:0] OFS_ID_REVISION_CODE = 12'h48D;
  localparam logic [11:0] OFS_ID_RESERVED = 12'h48F;
  localparam logic [11:0] OFS_ID_DRIVER_LOW = 12'h491;
  localparam logic [11:0] OFS_ID_DRIVER_HIGH = 12'h493;
  localparam logic [11:0] OFS_ID_USED_BYTES = 12'h495;
  localparam logic [11:0] OFS_ID_CHECKSUM = 12'h497;

  // ==========================================================================
  // Fixed values, reset values and field layouts
  // ==========================================================================
  localparam logic [7:0] ID_SIG_CHAR0 = 8'h49;
  localparam logic [7:0] ID_SIG_CHAR1 = 8'h50;
  localparam logic [7:0] ID_SIG_CHAR2 = 8'h41;
  localparam logic [7:0] ID_SIG_CHAR3 = 8'h43;
  localparam logic [7:0] ID_RESERVED = 8'h00;
  localparam logic [7:0] ID_DRIVER_HIGH = 8'h00;
  localparam logic [7:0] ID_USED_BYTES = 8'h0C;
  localparam logic [3:0] LAMP_RESET = 4'h0;
  localparam logic [3:0] UNUSED_HIGH_NIBBLE = 4'hF;
  localparam logic [5:0] UNUSED_HIGH_SIX = 6'h3F;
  localparam logic [7:0] EDGE_POLARITY_VALUE = 8'hFE;
  localparam logic [7:0] READ_ALL_ONES = 8'hFF;
  localparam logic [7:0] READ_NOTHING = 8'h00;
  localparam logic [1:0] ENABLE_RESET = 2'b00;
  localparam logic [7:0] VECTOR_UNINIT = 8'h0F;
  localparam logic [5:0] VECTOR_HIGH_RESET = 6'h00;
  localparam logic [1:0] SRC_RESERVED = 2'b00;
  localparam logic [1:0] SRC_POWER_FAIL = 2'b01;
  localparam logic [1:0] SRC_FLASH_READY = 2'b10;
  localparam int SRC_POWER_BIT = 0;
  localparam int SRC_FLASH_BIT = 1;

  // ==========================================================================
  // Interrupt map strap codes and bus address modifiers
  // ==========================================================================
  localparam logic [2:0] MAP_LEGACY = 3'h0;
  localparam logic [2:0] MAP_DISABLED = 3'h7;
  localparam logic [5:0] AM_SHORT_SUPER = 6'h2D;
  localparam logic [5:0] AM_SHORT_USER = 6'h29;

  // Bus-side inputs, sampled as synchronous to the system clock.
  typedef struct packed {
    logic as_n;
    logic ds1_n;
    logic ds0_n;
    logic write_n;
    logic iack_n;
    logic iackin_n;
    logic [5:0] am;
    logic [15:1] addr;
    logic [15:0] data;
  } cdir_bus_in_t;

endpackage

// ---- cdir_carrier_diag.sv ----
// Carrier diagnostic module: lamps, live status, edge interrupts, vector, ID.
// Functional notes
// - Lamp bit one green, zero red.
// - Lamp bits reset zero, upper nibble reads ones.
// - Status bit0 power good, bit1 flash ready.
// - Power lamp green when good, else off.
// - Status bits readable in every mapping mode.
// - Diagnostic interrupts only in single-level modes.
// - Polarity register fixed, reads 0xFE.
// - Latch power fall and flash rise edges.
// - Enable bits reset zero, independent per source.
// - Request when pending and enabled both set.
// - Clear writes one to clear, zero ignored.
// - Pending latches untouched by reset.
// - Vector high six host bits, low source.
// - Both pending and enabled gives power code, both shown.
// - Unwritten vector reads fixed uninitialised value.
// - Legacy map slots to levels one to seven.
// - Read-only ID bytes at odd addresses.
// - Single level shared, straps pick or disable.
// - Window base from straps on A15..A12.
`timescale 1ns/10ps
`default_nettype none

module cdir_carrier_diag #(
  parameter logic [7:0] ID_MAKER_CODE = 8'h11,    // Arbitrary value.
  parameter logic [7:0] ID_MODEL_CODE = 8'h22,    // Arbitrary value.
  parameter logic [7:0] ID_REVISION_CODE = 8'h33, // Arbitrary value.
  parameter logic [7:0] ID_DRIVER_LOW = 8'h00,    // Arbitrary value.
  parameter logic [7:0] ID_CHECKSUM = 8'h44,      // Arbitrary value.
  parameter int LAMP_PAIRS = 4,
  parameter int SLOT_IRQS = 8
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire cdir_pkg::cdir_bus_in_t I_BUS,
  input wire logic [3:0] I_IO_BASE_STRAPS,
  input wire logic [2:0] I_IRQ_MAP_STRAPS,
  input wire logic I_POWER_OK,
  input wire logic I_FLASH_READY_BUSY,
  input wire logic [SLOT_IRQS-1:0] I_SLOT_IRQ_N,
  output logic [15:0] O_DATA,
  output logic O_DATA_OE,
  output logic O_DTACK_N,
  output logic O_DTACK_OE,
  output logic O_IACKOUT_N,
  output logic [7:1] O_IRQ_N,
  output logic [7:1] O_IRQ_OE,
  output logic [LAMP_PAIRS-1:0] O_LAMP_GREEN,
  output logic [LAMP_PAIRS-1:0] O_LAMP_RED,
  output logic O_POWER_STATUS_LAMP
);

  // ==========================================================================
  // Cycle state machine
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK = 3'b010,
    ST_PASS = 3'b100
  } cdir_state_t;

  cdir_state_t state;
  cdir_state_t next_state;
  logic [3:0] lamp_control;
  logic [1:0] irq_enable_mask;
  logic [1:0] pending_latches;
  logic [5:0] vector_high;
  logic vector_written;
  logic power_prev;
  logic flash_prev;
  logic power_lamp;
  logic read_cycle;
  logic [7:0] read_data;
  logic [7:0] vector_value;
  logic [1:0] source_code;
  logic [1:0] edge_set;
  logic [1:0] clear_hit;
  logic [11:0] byte_ofs;
  logic strobe_low;
  logic any_strobe;
  logic short_am;
  logic reg_hit;
  logic start;
  logic reg_access;
  logic iack_cycle;
  logic own_iack;
  logic wr_stb;
  logic lamp_wr;
  logic enable_wr;
  logic clear_wr;
  logic vector_wr;
  logic single_mode;
  logic diag_irq;
  logic [7:1] irq_req;
  logic [7:1] next_irq_oe;

  // Decodes one byte offset of the ID area; odd offsets only.
  function automatic logic [7:0] id_byte(input logic [11:0] ofs);
    case (ofs)
      cdir_pkg::OFS_ID_SIG_CHAR0: id_byte = cdir_pkg::ID_SIG_CHAR0;
      cdir_pkg::OFS_ID_SIG_CHAR1: id_byte = cdir_pkg::ID_SIG_CHAR1;
      cdir_pkg::OFS_ID_SIG_CHAR2: id_byte = cdir_pkg::ID_SIG_CHAR2;
      cdir_pkg::OFS_ID_SIG_CHAR3: id_byte = cdir_pkg::ID_SIG_CHAR3;
      cdir_pkg::OFS_ID_MAKER_CODE: id_byte = ID_MAKER_CODE;
      cdir_pkg::OFS_ID_MODEL_CODE: id_byte = ID_MODEL_CODE;
      cdir_pkg::OFS_ID_REVISION_CODE: id_byte = ID_REVISION_CODE;
      cdir_pkg::OFS_ID_RESERVED: id_byte = cdir_pkg::ID_RESERVED;
      cdir_pkg::OFS_ID_DRIVER_LOW: id_byte = ID_DRIVER_LOW;
      cdir_pkg::OFS_ID_DRIVER_HIGH: id_byte = cdir_pkg::ID_DRIVER_HIGH;
      cdir_pkg::OFS_ID_USED_BYTES: id_byte = cdir_pkg::ID_USED_BYTES;
      cdir_pkg::OFS_ID_CHECKSUM: id_byte = ID_CHECKSUM;
      default: id_byte = cdir_pkg::READ_NOTHING;
    endcase
  endfunction

  // Registers sit one above their even offset, on the low byte lane.
  function automatic logic odd_hit(input logic [11:0] ofs,
      input logic [11:0] reg_ofs);
    odd_hit = (ofs == {reg_ofs[11:1], 1'b1});
  endfunction

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Only the low byte lane carries register data, so every register and
  // ID byte sits at an odd byte address with DS0 active.
  assign byte_ofs = {I_BUS.addr[11:1], 1'b1};
  assign strobe_low = ~I_BUS.ds0_n;
  assign any_strobe = ~I_BUS.ds0_n | ~I_BUS.ds1_n;
  assign short_am = (I_BUS.am == cdir_pkg::AM_SHORT_SUPER) ||
                    (I_BUS.am == cdir_pkg::AM_SHORT_USER);
  assign reg_hit = (I_BUS.addr[15:12] == I_IO_BASE_STRAPS) &&
                   (I_BUS.addr[11:8] == cdir_pkg::DIAG_PAGE);
  assign start = (state == ST_IDLE) && !I_BUS.as_n && any_strobe;
  assign reg_access = start && I_BUS.iack_n && short_am && reg_hit;
  assign iack_cycle = start && !I_BUS.iack_n && !I_BUS.iackin_n;
  // Only the diagnostic request is answered here; slot vectors belong to
  // the slots themselves, so their acknowledge is passed down the chain.
  assign own_iack = iack_cycle && diag_irq &&
                    (I_BUS.addr[3:1] == I_IRQ_MAP_STRAPS);
  assign wr_stb = reg_access && !I_BUS.write_n && strobe_low;

  // ==========================================================================
  // Register write decode
  // ==========================================================================
  assign lamp_wr = wr_stb && odd_hit(byte_ofs, cdir_pkg::OFS_LAMP_CONTROL);
  assign enable_wr = wr_stb &&
                     odd_hit(byte_ofs, cdir_pkg::OFS_IRQ_ENABLE_MASK);
  assign clear_wr = wr_stb && odd_hit(byte_ofs, cdir_pkg::OFS_PENDING_CLEAR);
  assign vector_wr = wr_stb && odd_hit(byte_ofs, cdir_pkg::OFS_IRQ_VECTOR);

  // ==========================================================================
  // Interrupt sources and mapping
  // ==========================================================================
  assign single_mode = (I_IRQ_MAP_STRAPS != cdir_pkg::MAP_LEGACY) &&
                       (I_IRQ_MAP_STRAPS != cdir_pkg::MAP_DISABLED);
  // Diagnostic requests are held back entirely in legacy and disabled
  // modes, since the legacy map has no level reserved for them.
  assign diag_irq = single_mode &&
                    |(pending_latches & irq_enable_mask);

  // Falling edge of power good, rising edge of flash ready.
  assign edge_set[cdir_pkg::SRC_POWER_BIT] = power_prev && !I_POWER_OK;
  assign edge_set[cdir_pkg::SRC_FLASH_BIT] = !flash_prev &&
                                             I_FLASH_READY_BUSY;

  assign clear_hit = clear_wr ? I_BUS.data[1:0] : 2'b00;

  // Power source wins whenever both are pending and enabled.
  always_comb begin
    if (pending_latches[cdir_pkg::SRC_POWER_BIT] &&
        irq_enable_mask[cdir_pkg::SRC_POWER_BIT]) begin
      source_code = cdir_pkg::SRC_POWER_FAIL;
    end else if (pending_latches[cdir_pkg::SRC_FLASH_BIT] &&
                 irq_enable_mask[cdir_pkg::SRC_FLASH_BIT]) begin
      source_code = cdir_pkg::SRC_FLASH_READY;
    end else begin
      source_code = cdir_pkg::SRC_RESERVED;
    end
  end

  // The fixed value wins over the source code until software has written
  // a vector at least once; only a reset brings it back.
  assign vector_value = vector_written ? {vector_high, source_code} :
                        cdir_pkg::VECTOR_UNINIT;

  // In single-level mode every slot request and the diagnostic request
  // share the strapped level; in legacy mode slot lines 0 to 6 each have their own and slot line 7 has none.
  genvar lvl;
  generate
    for (lvl = 1; lvl <= 7; lvl++) begin : g_level
      always_comb begin
        if (I_IRQ_MAP_STRAPS == cdir_pkg::MAP_LEGACY) begin
          irq_req[lvl] = !I_SLOT_IRQ_N[lvl-1];
        end else if (single_mode && I_IRQ_MAP_STRAPS == 3'(lvl)) begin
          irq_req[lvl] = diag_irq || !(&I_SLOT_IRQ_N);
        end else begin
          irq_req[lvl] = 1'b0;
        end
      end
    end
  endgenerate

  assign next_irq_oe = irq_req;

  // Levels are registered so that a decode glitch never reaches the
  // backplane as a runt request. The price is one cycle of latency.

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_IRQ_OE <= '0;
    end else begin
      O_IRQ_OE <= next_irq_oe;
    end
  end

  // ==========================================================================
  // Read multiplexer
  // ==========================================================================
  always_comb begin
    case (byte_ofs)
      cdir_pkg::OFS_LAMP_CONTROL + 12'h001: begin
        read_data = {cdir_pkg::UNUSED_HIGH_NIBBLE, lamp_control};
      end
      cdir_pkg::OFS_LIVE_STATUS + 12'h001: begin
        read_data = {cdir_pkg::UNUSED_HIGH_SIX, I_FLASH_READY_BUSY,
                     I_POWER_OK};
      end
      cdir_pkg::OFS_EDGE_POLARITY + 12'h001: begin
        read_data = cdir_pkg::EDGE_POLARITY_VALUE;
      end
      cdir_pkg::OFS_IRQ_ENABLE_MASK + 12'h001: begin
        read_data = {cdir_pkg::UNUSED_HIGH_SIX, irq_enable_mask};
      end
      cdir_pkg::OFS_PENDING_CLEAR + 12'h001: begin
        read_data = cdir_pkg::READ_ALL_ONES;
      end
      cdir_pkg::OFS_PENDING_LATCHES + 12'h001: begin
        read_data = {cdir_pkg::UNUSED_HIGH_SIX, pending_latches};
      end
      cdir_pkg::OFS_IRQ_VECTOR + 12'h001: begin
        read_data = vector_value;
      end
      default: begin
        read_data = id_byte(byte_ofs);
      end
    endcase
  end

  // ==========================================================================
  // Bus cycle sequencing
  // ==========================================================================
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (reg_access || own_iack) begin
          next_state = ST_ACK;
        end else if (iack_cycle) begin
          next_state = ST_PASS;
        end
      end
      // The acknowledge stands until both data strobes are released, so
      // a slow master never sees it vanish under a strobe it still holds.
      ST_ACK: begin
        if (I_BUS.ds0_n && I_BUS.ds1_n) begin
          next_state = ST_IDLE;
        end
      end
      // A cycle for another level keeps the chain passed on until the
      // address strobe ends it.
      ST_PASS: begin
        if (I_BUS.as_n) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Read data is frozen at the start of the cycle so it stays stable
  // for the whole time DTACK is held.
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DATA <= 16'h0000;
      read_cycle <= 1'b0;
    end else if (own_iack) begin
      O_DATA <= {8'h00, vector_value};
      read_cycle <= 1'b1;
    end else if (reg_access) begin
      O_DATA <= {8'h00, strobe_low ? read_data : cdir_pkg::READ_NOTHING};
      read_cycle <= I_BUS.write_n;
    end
  end

  // Only the low lane carries data; a word read therefore sees zero in the
  // upper byte.
  assign O_DATA_OE = (state == ST_ACK) && read_cycle;
  assign O_DTACK_N = 1'b0;
  assign O_DTACK_OE = (state == ST_ACK);
  assign O_IACKOUT_N = !(state == ST_PASS);
  assign O_IRQ_N = '0;

  // ==========================================================================
  // Software-written registers
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      lamp_control <= cdir_pkg::LAMP_RESET;
    end else if (lamp_wr) begin
      lamp_control <= I_BUS.data[3:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_enable_mask <= cdir_pkg::ENABLE_RESET;
    end else if (enable_wr) begin
      irq_enable_mask <= I_BUS.data[1:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      vector_high <= cdir_pkg::VECTOR_HIGH_RESET;
      vector_written <= 1'b0;
    end else if (vector_wr) begin
      vector_high <= I_BUS.data[7:2];
      vector_written <= 1'b1;
    end
  end

  // ==========================================================================
  // Edge latches and lamps
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      power_prev <= 1'b1;
      flash_prev <= 1'b1;
      power_lamp <= 1'b0;
    end else begin
      power_prev <= I_POWER_OK;
      flash_prev <= I_FLASH_READY_BUSY;
      power_lamp <= I_POWER_OK;
    end
  end

  // Deliberately outside reset: contents after power-up are unknown, so
  // software must clear them before enabling. A new edge in the same
  // cycle as a clear keeps the latch set.
  always_ff @(posedge I_SYS_CLK) begin
    pending_latches <= (pending_latches & ~clear_hit) |
                       edge_set;
  end

  assign O_LAMP_GREEN = lamp_control;
  assign O_LAMP_RED = ~lamp_control;
  assign O_POWER_STATUS_LAMP = power_lamp;

endmodule

`default_nettype wire

// ---- cdir_chk_chk.sv ----
// Checker of bus handshake, lamps and interrupt routing at the pins.
`timescale 1ns/10ps
`default_nettype none
module cdir_chk #(
  parameter int LAMP_PAIRS = 4,
  parameter int SLOT_IRQS = 8
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire cdir_pkg::cdir_bus_in_t I_BUS,
  input wire logic [3:0] I_IO_BASE_STRAPS,
  input wire logic [2:0] I_IRQ_MAP_STRAPS,
  input wire logic I_POWER_OK,
  input wire logic [SLOT_IRQS-1:0] I_SLOT_IRQ_N,
  input wire logic O_DATA_OE,
  input wire logic O_DTACK_OE,
  input wire logic O_IACKOUT_N,
  input wire logic [7:1] O_IRQ_OE,
  input wire logic [LAMP_PAIRS-1:0] O_LAMP_GREEN,
  input wire logic [LAMP_PAIRS-1:0] O_LAMP_RED,
  input wire logic O_POWER_STATUS_LAMP
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  logic sel;
  logic [2:0] map;
  assign map = I_IRQ_MAP_STRAPS;
  assign sel = !I_BUS.as_n && I_BUS.iack_n &&
    I_BUS.addr[15:12] == I_IO_BASE_STRAPS &&
    I_BUS.addr[11:8] == cdir_pkg::DIAG_PAGE &&
    (I_BUS.am == cdir_pkg::AM_SHORT_USER ||
     I_BUS.am == cdir_pkg::AM_SHORT_SUPER);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_lamp_pair: assert property (O_LAMP_RED == ~O_LAMP_GREEN)
    else $error("red lamps not inverse of green");
  a_power_lamp: assert property (!$past(I_RST) |->
    O_POWER_STATUS_LAMP == $past(I_POWER_OK))
    else $error("power lamp does not follow power level");
  a_dtack_start: assert property ($fell(I_BUS.ds0_n) && sel |=>
    O_DTACK_OE) else $error("no acknowledge one cycle after request");
  a_dtack_hold: assert property (O_DTACK_OE &&
    !(I_BUS.ds0_n && I_BUS.ds1_n) |=> O_DTACK_OE)
    else $error("acknowledge dropped while strobes held");
  a_dtack_drop: assert property (O_DTACK_OE &&
    I_BUS.ds0_n && I_BUS.ds1_n |=> !O_DTACK_OE)
    else $error("acknowledge kept after strobes released");
  a_read_drive: assert property (O_DTACK_OE |->
    O_DATA_OE == I_BUS.write_n)
    else $error("data drive wrong for the kind of cycle");
  a_foreign_base: assert property ($fell(I_BUS.ds0_n) &&
    I_BUS.iack_n && I_BUS.addr[15:12] != I_IO_BASE_STRAPS |=>
    !O_DTACK_OE [*2]) else $error("answered outside its base");
  a_irq_single: assert property (map inside {[3'h1:3'h6]} &&
    $past(map) == map && $past(map, 2) == map |->
    $onehot0(O_IRQ_OE) && (O_IRQ_OE == 7'h00 || O_IRQ_OE[map]))
    else $error("request on a level other than the strapped one");
  a_irq_quiet: assert property ($past(map) == map &&
    $past(map, 2) == map && (map == cdir_pkg::MAP_DISABLED ||
    (map == cdir_pkg::MAP_LEGACY && &I_SLOT_IRQ_N && $past(&I_SLOT_IRQ_N)))
    |-> O_IRQ_OE == 7'h00) else $error("request with no mapped source");
  a_legacy_map: assert property (map == cdir_pkg::MAP_LEGACY &&
    $past(map) == map && !$past(I_RST) |->
    O_IRQ_OE == ~$past(I_SLOT_IRQ_N[6:0]))
    else $error("legacy slot map wrong");
  c_read: cover property (O_DATA_OE && I_BUS.write_n);
  c_pass: cover property (!O_IACKOUT_N);
  c_diag: cover property (map != 3'h0 && O_IRQ_OE != 7'h00);
endmodule
bind cdir_carrier_diag cdir_chk #(.LAMP_PAIRS(LAMP_PAIRS),
  .SLOT_IRQS(SLOT_IRQS)) u_chk (.I_SYS_CLK, .I_RST, .I_BUS,
  .I_IO_BASE_STRAPS, .I_IRQ_MAP_STRAPS, .I_POWER_OK, .I_SLOT_IRQ_N,
  .O_DATA_OE, .O_DTACK_OE, .O_IACKOUT_N, .O_IRQ_OE, .O_LAMP_GREEN,
  .O_LAMP_RED, .O_POWER_STATUS_LAMP);
`default_nettype wire

// ---- cdir_host.sv ----
// Host model issuing short I/O and interrupt acknowledge cycles.
`timescale 1ns/10ps
`default_nettype none
module cdir_host (
  input wire logic i_clk,
  input wire logic [3:0] i_base,
  input wire logic i_dtack_oe,
  input wire logic i_iackout_n,
  input wire logic [15:0] i_data,
  output var cdir_pkg::cdir_bus_in_t o_bus
);
  initial begin
    o_bus = '1;
    o_bus.am = cdir_pkg::AM_SHORT_USER;
  end
  // The request stands until the answer is sampled; a bus nobody drives
  // must not look like the last write, so data is inverted on release.
  task automatic cyc(input logic iack, input logic wr, input logic [11:0] a,
      input logic [7:0] wd, output logic [7:0] rd, output logic ak);
    logic done;
    done = 1'h0;
    ak = 1'h0;
    @(posedge i_clk);
    o_bus.addr <= {i_base, a[11:1]};
    o_bus.data <= {8'h00, wd};
    o_bus.write_n <= ~wr;
    o_bus.iack_n <= ~iack;
    o_bus.iackin_n <= ~iack;
    o_bus.as_n <= 1'h0;
    o_bus.ds0_n <= 1'h0;
    for (int n = 0; n < 8 && !done; n++) begin
      @(posedge i_clk);
      ak = i_dtack_oe;
      done = i_dtack_oe || !i_iackout_n;
    end
    rd = i_data[7:0];
    o_bus.as_n <= 1'h1;
    o_bus.ds0_n <= 1'h1;
    o_bus.iack_n <= 1'h1;
    o_bus.iackin_n <= 1'h1;
    o_bus.data <= ~o_bus.data;
    for (int n = 0; n < 8 && (i_dtack_oe || !i_iackout_n); n++) begin
      @(posedge i_clk);
    end
    if (i_dtack_oe) begin
      ak = 1'h0;
    end
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the carrier diagnostic register block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value.
  localparam logic [7:0] MD = 8'h6C; // Arbitrary value.
  localparam logic [7:0] RV = 8'h7E; // Arbitrary value.
  localparam logic [7:0] DL = 8'h01; // Arbitrary value.
  localparam logic [7:0] CK = 8'h9D; // Arbitrary value.
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] hbase = 4'h6;
  logic [3:0] sbase = 4'h6;
  logic [2:0] map = 3'h2;
  logic pwr = 1'h1;
  logic fl = 1'h1;
  logic [7:0] slot = 8'hFF;
  cdir_pkg::cdir_bus_in_t bus;
  logic [15:0] dat;
  logic dto;
  logic ion;
  logic [7:1] irq;
  logic [3:0] grn;
  logic [3:0] red;
  logic plamp;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] idv [12] = '{8'h49, 8'h50, 8'h41, 8'h43, MK, MD, RV, 8'h00,
    DL, 8'h00, 8'h0C, CK};
  always #5 clk = ~clk;
  cdir_host host (.i_clk(clk), .i_base(hbase), .i_dtack_oe(dto),
    .i_iackout_n(ion), .i_data(dat), .o_bus(bus));
  cdir_carrier_diag #(.ID_MAKER_CODE(MK), .ID_MODEL_CODE(MD),
    .ID_REVISION_CODE(RV), .ID_DRIVER_LOW(DL), .ID_CHECKSUM(CK)) dut (
    .I_SYS_CLK(clk), .I_RST(rst), .I_BUS(bus), .I_IO_BASE_STRAPS(sbase),
    .I_IRQ_MAP_STRAPS(map), .I_POWER_OK(pwr), .I_FLASH_READY_BUSY(fl),
    .I_SLOT_IRQ_N(slot), .O_DATA(dat), .O_DATA_OE(), .O_DTACK_N(),
    .O_DTACK_OE(dto), .O_IACKOUT_N(ion), .O_IRQ_N(), .O_IRQ_OE(irq),
    .O_LAMP_GREEN(grn), .O_LAMP_RED(red), .O_POWER_STATUS_LAMP(plamp));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic acc(input logic ia, input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [7:0] v);
    logic ak;
    host.cyc(ia, w, a, d, v, ak);
    if (ak !== 1'h1) begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] v;
    acc(1'h0, 1'h1, a, d, v);
  endtask
  task automatic rd(input string w, input logic [11:0] a,
      input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    acc(1'h0, 1'h0, a, 8'h00, v);
    chk(w, v & m, e);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_lamp();
    chk("green", 8'(grn), 8'h00);
    chk("red", 8'(red), 8'h0F);
    rd("lamp", 12'h400, 8'hFF, 8'hF0);
    rd("enable", 12'h406, 8'h03, 8'h00);
    rd("vector", 12'h40C, 8'hFF, 8'h0F);
    wr(12'h400, 8'h5A);
    rd("lamp", 12'h400, 8'hFF, 8'hFA);
    chk("green", 8'(grn), 8'h0A);
    chk("red", 8'(red), 8'h05);
  endtask
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      map <= i[2] ? 3'h0 : 3'h2;
      pwr <= i[0];
      fl <= i[1];
      tick(2);
      rd("status", 12'h402, 8'h03, 8'(i[1:0]));
      chk("power lamp", 8'(plamp), 8'(i[0]));
    end
  endtask
  task automatic t_fixed();
    logic [7:0] v;
    logic ak;
    rd("polarity", 12'h404, 8'hFF, 8'hFE);
    rd("clear", 12'h408, 8'hFF, 8'hFF);
    rd("unmapped", 12'h41E, 8'hFF, 8'h00);
    host.o_bus.am <= cdir_pkg::AM_SHORT_SUPER;
    for (int i = 0; i < 12; i++) begin
      rd("id", 12'h481 + 12'(2 * i), 8'hFF, idv[i]);
    end
    hbase <= 4'h3;
    host.cyc(1'h0, 1'h0, 12'h400, 8'h00, v, ak);
    chk("foreign ack", 8'(ak), 8'h00);
    sbase <= 4'h3;
    rd("moved base", 12'h400, 8'hFF, 8'hFA);
    sbase <= 4'h6;
    hbase <= 4'h6;
  endtask
  task automatic t_irq();
    logic [7:0] v;
    logic ak;
    map <= 3'h2;
    wr(12'h408, 8'hFF);
    rd("pending", 12'h40A, 8'h03, 8'h00);
    wr(12'h406, 8'h03);
    wr(12'h40C, 8'hA8);
    rd("vector", 12'h40C, 8'hFF, 8'hA8);
    pwr <= 1'h0;
    tick(3);
    chk("irq", 8'(irq), 8'h02);
    rd("pending", 12'h40A, 8'h03, 8'h01);
    fl <= 1'h0;
    tick(2);
    fl <= 1'h1;
    tick(3);
    rd("pending", 12'h40A, 8'h03, 8'h03);
    rd("vector", 12'h40C, 8'hFF, 8'hA9);
    acc(1'h1, 1'h0, 12'h004, 8'h00, v);
    chk("iack vector", v, 8'hA9);
    host.cyc(1'h1, 1'h0, 12'h00A, 8'h00, v, ak);
    chk("other level ack", 8'(ak), 8'h00);
    wr(12'h408, 8'h01);
    rd("pending", 12'h40A, 8'h03, 8'h02);
    rd("vector", 12'h40C, 8'hFF, 8'hAA);
    wr(12'h408, 8'h02);
    tick(2);
    chk("irq", 8'(irq), 8'h00);
    wr(12'h406, 8'h02);
    pwr <= 1'h1;
    tick(2);
    pwr <= 1'h0;
    tick(3);
    chk("masked irq", 8'(irq), 8'h00);
    rd("vector", 12'h40C, 8'hFF, 8'hA8);
    map <= 3'h0;
    wr(12'h406, 8'h01);
    tick(2);
    chk("legacy irq", 8'(irq), 8'h00);
  endtask
  task automatic t_map();
    for (int i = 0; i < 8; i++) begin
      slot <= ~(8'h01 << i);
      tick(3);
      chk("slot irq", 8'(irq), i < 7 ? 8'h01 << i : 8'h00);
    end
    map <= 3'h7;
    slot <= 8'h00;
    tick(3);
    chk("disabled irq", 8'(irq), 8'h00);
    map <= 3'h4;
    slot <= 8'hFE;
    tick(3);
    chk("single irq", 8'(irq), 8'h08);
  endtask
  initial begin
    tick(2);
    rst <= 1'h0;
    tick(1);
    t_lamp();
    t_status();
    t_fixed();
    t_irq();
    t_map();
    stop_test();
  end
endmodule
`default_nettype wire
